/* File: logic/nsd_cfg.svh */
`ifndef NSD_CFG_SVH
`define NSD_CFG_SVH
// ==========================================================================
// Overview of operation
// RQ1: Operating quantity is selected sequence magnitude minus factor times positive magnitude.
// RQ2: Restraint factor scales the positive term; zero removes restraint entirely.
// RQ3: Software should use 0.063 in zero mode or 0.125 in negative mode; reset loads 0.063 with negative mode selected.
// RQ4: Direction uses only negative-sequence voltage and current, whatever the mode.
// RQ5: Forward when polarizing phasor lies within forward limit of current rotated by angle.
// RQ6: Reverse uses the same phasor against the negated reference, within reverse limit.
// RQ7: Polarizing is valid only above the voltage floor; otherwise no indication at all.
// RQ8: Forward flag needs operating quantity above forward threshold and forward direction.
// RQ9: Reverse flag needs operating quantity above reverse threshold and reverse direction.
// RQ10: After reverse for 1.25 power cycles, forward is withheld for 1.5 cycles.
// RQ11: Offset impedance is taken in secondary ohms.
// RQ12: Pickup thresholds span 0.05 to 30.00 per-unit in 0.01 steps.
// RQ13: Restraint factor spans 0.000 to 0.500 in 0.001 steps.
// RQ14: Characteristic angle spans 0 to 90 degrees in one-degree steps.
// RQ15: Forward and reverse limit angles span 40 to 90 degrees in one-degree steps.
// RQ16: Disabled element or asserted block input holds both flags low.

// ==========================================================================
// Register map, word aligned byte addresses.
`define NSD_AW              8
`define NSD_DW              32
`define NSD_A_CTRL          8'h00
`define NSD_A_OFFSET        8'h04
`define NSD_A_RESTRAINT     8'h08
`define NSD_A_ANGLE         8'h0C
`define NSD_A_FWD_LIMIT     8'h10
`define NSD_A_REV_LIMIT     8'h14
`define NSD_A_FWD_PICKUP    8'h18
`define NSD_A_REV_PICKUP    8'h1C
`define NSD_A_VFLOOR        8'h20
`define NSD_A_STATUS        8'h24
`define NSD_A_IRQ_STAT      8'h28
`define NSD_A_IRQ_MASK      8'h2C

// ==========================================================================
// Field positions.
`define NSD_CTRL_EN         0
`define NSD_CTRL_SEQ        1
`define NSD_ST_FWD          0
`define NSD_ST_REV          1
`define NSD_ST_DIR_FWD      2
`define NSD_ST_DIR_REV      3
`define NSD_ST_POL_OK       4
`define NSD_ST_HELD         5
`define NSD_ST_ACTIVE       6
`define NSD_EV_W            3
`define NSD_EV_FWD          0
`define NSD_EV_REV          1
`define NSD_EV_HOLD         2

// ==========================================================================
// Setting ranges and reset values.
`define NSD_OFFSET_MAX      15'h61A8
`define NSD_K_MAX           9'h1F4
`define NSD_K_RST           9'h03F
`define NSD_ANGLE_MAX       7'h5A
`define NSD_ANGLE_RST       7'h4B
`define NSD_LIM_MIN         7'h28
`define NSD_LIM_MAX         7'h5A
`define NSD_PU_MIN          12'h005
`define NSD_PU_MAX          12'hBB8
`define NSD_VFLOOR_RST      16'h0010

// ==========================================================================
// Arithmetic scaling.
`define NSD_OHM_DIV         32'sh64
`define NSD_K_SCALE         34'sh3E8
`define NSD_X_SHIFT         9
`define NSD_Q               15
`define NSD_BH_K            32'h7E90
`define NSD_FRAC_W          30

// ==========================================================================
// Timing, in power system cycles scaled by one hundred.
`define NSD_CLK_HZ          64'h5F5E100
`define NSD_SYS_HZ          64'h3C
`define NSD_CENTI           64'h64
`define NSD_REV_HOLD_CENTI  64'h7D
`define NSD_FWD_HOLD_CENTI  64'h96
`define NSD_REV_HOLD_CLKS   ((`NSD_CLK_HZ * `NSD_REV_HOLD_CENTI + `NSD_CENTI * `NSD_SYS_HZ - \
                             64'h1) / (`NSD_CENTI * `NSD_SYS_HZ))
`define NSD_FWD_HOLD_CLKS   ((`NSD_CLK_HZ * `NSD_FWD_HOLD_CENTI + `NSD_CENTI * `NSD_SYS_HZ - \
                             64'h1) / (`NSD_CENTI * `NSD_SYS_HZ))
`define NSD_CNT_W           22

`endif

/* File: logic/nsd_pkg.sv */
`include "nsd_cfg.svh"

package nsd_pkg;

  // ========================================================================
  // Port and state types.
  typedef logic [`NSD_AW-1:0]        nsd_addr_type;
  typedef logic [`NSD_DW-1:0]        nsd_word_type;
  typedef logic [15:0]               nsd_mag_type;
  typedef logic signed [15:0]        nsd_cpx_type;
  typedef logic [`NSD_CNT_W-1:0]     nsd_cnt_type;

  typedef enum logic {
    NSD_SEQ_NEG,
    NSD_SEQ_ZERO
  } nsd_seq_type;

  typedef struct packed {
    logic                  enable;
    nsd_seq_type           sequence_select;
    logic [14:0]           offset_impedance;
    logic [8:0]            positive_restraint_factor;
    logic [6:0]            characteristic_angle;
    logic [6:0]            forward_angle_limit;
    logic [6:0]            reverse_angle_limit;
    logic [11:0]           forward_threshold;
    logic [11:0]           reverse_threshold;
    logic [15:0]           polarizing_voltage_floor;
    logic [`NSD_EV_W-1:0]  irq_stat;
    logic [`NSD_EV_W-1:0]  irq_mask;
    nsd_cnt_type           rev_cnt;
    nsd_cnt_type           hold_cnt;
    logic                  fwd;
    logic                  rev;
    logic                  irq;
    nsd_word_type          rd_data;
  } nsd_state_type;

endpackage

/* File: logic/nsd_sector.sv */
`timescale 1ns/100ps
`include "nsd_cfg.svh"

// ==========================================================================
// Sector test: true when the angle of re + j*im lies within the limit whose
// cosine is lim_cos. Squares replace a square root, so the test only works for
// limits up to 90 degrees, which the setting range guarantees.
module nsd_sector (
  // Phasor under test.
  input  wire logic signed [31:0] i_re,
  input  wire logic signed [31:0] i_im,
  // Cosine of the limit angle.
  input  wire logic [15:0]        i_lim_cos,
  // Result.
  output logic                    o_within
);
  logic [95:0] re_sq;
  logic [95:0] lhs;
  logic [95:0] rhs;

  assign re_sq    = 96'(i_re * 64'(1) * i_re);
  assign lhs      = re_sq << `NSD_FRAC_W;
  assign rhs      = (re_sq + 96'(64'(i_im) * 64'(i_im))) * 96'(32'(i_lim_cos) * 32'(i_lim_cos));
  assign o_within = (i_re > 32'sh0) && (lhs >= rhs);
endmodule

/* File: logic/nsd_top.sv */
`timescale 1ns/100ps
`include "nsd_cfg.svh"

module nsd_top #(
  parameter nsd_pkg::nsd_cnt_type P_REV_HOLD_CLKS = `NSD_CNT_W'(`NSD_REV_HOLD_CLKS),
  parameter nsd_pkg::nsd_cnt_type P_FWD_HOLD_CLKS = `NSD_CNT_W'(`NSD_FWD_HOLD_CLKS)
) (
  // Clock and reset.
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  // Register port.
  input  wire nsd_pkg::nsd_addr_type i_addr,
  input  wire nsd_pkg::nsd_word_type i_wr_data,
  input  wire logic                 i_wr_en,
  input  wire logic                 i_rd_en,
  output nsd_pkg::nsd_word_type     o_rd_data,
  // Sequence quantities from the selected source.
  input  wire nsd_pkg::nsd_mag_type i_i0_mag,
  input  wire nsd_pkg::nsd_mag_type i_i1_mag,
  input  wire nsd_pkg::nsd_mag_type i_i2_mag,
  input  wire nsd_pkg::nsd_mag_type i_v2_mag,
  input  wire nsd_pkg::nsd_cpx_type i_i2_re,
  input  wire nsd_pkg::nsd_cpx_type i_i2_im,
  input  wire nsd_pkg::nsd_cpx_type i_v2_re,
  input  wire nsd_pkg::nsd_cpx_type i_v2_im,
  // Block input.
  input  wire logic                 i_block,
  // Indications.
  output logic                      o_forward_fault_flag,
  output logic                      o_reverse_fault_flag,
  output logic                      o_irq
);
  import nsd_pkg::*;

  // ========================================================================
  // Helpers.
  function automatic logic [15:0] nsd_cos(input logic [6:0] deg);
    logic [31:0] x2;
    logic [47:0] num;
    logic [47:0] den;
    x2  = 32'(deg) * 32'(deg);
    num = 48'(`NSD_BH_K - (x2 << 2)) << `NSD_Q;
    den = 48'(`NSD_BH_K + x2);
    return 16'(num / den);
  endfunction

  function automatic logic [15:0] nsd_clamp(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  nsd_state_type q;
  nsd_state_type d;

  // ========================================================================
  // Overcurrent unit.
  logic [15:0]        sel_mag;
  logic signed [33:0] op_q;
  logic signed [33:0] fwd_lim;
  logic signed [33:0] rev_lim;
  logic               ov_fwd;
  logic               ov_rev;

  assign sel_mag = (q.sequence_select == NSD_SEQ_ZERO) ? i_i0_mag : i_i2_mag;  // [RQ1]
  assign op_q    = 34'($signed({18'h0, sel_mag})) * `NSD_K_SCALE
                 - 34'($signed({18'h0, i_i1_mag})) * 34'($signed({25'h0,
                   q.positive_restraint_factor}));                           // [RQ1] [RQ2]
  assign fwd_lim = 34'($signed({22'h0, q.forward_threshold})) * `NSD_K_SCALE;
  assign rev_lim = 34'($signed({22'h0, q.reverse_threshold})) * `NSD_K_SCALE;
  assign ov_fwd  = op_q > fwd_lim;  // [RQ8]
  assign ov_rev  = op_q > rev_lim;  // [RQ9]

  // ========================================================================
  // Directional unit, negative-sequence quantities only.
  logic signed [31:0] off_s;
  logic signed [31:0] z_re;
  logic signed [31:0] z_im;
  logic signed [31:0] p_re;
  logic signed [31:0] p_im;
  logic signed [63:0] x_re;
  logic signed [63:0] x_im;
  logic signed [31:0] xs_re;
  logic signed [31:0] xs_im;
  logic signed [31:0] cos_e;
  logic signed [31:0] sin_e;
  logic signed [63:0] y_re;
  logic signed [63:0] y_im;
  logic signed [31:0] ys_re;
  logic signed [31:0] ys_im;
  logic signed [31:0] yn_re;
  logic signed [31:0] yn_im;
  logic               in_fwd;
  logic               in_rev;
  logic               pol_valid;
  logic               dir_fwd;
  logic               dir_rev;

  assign off_s = $signed({17'h0, q.offset_impedance});
  assign z_re  = (off_s * 32'(i_i2_re)) / `NSD_OHM_DIV;  // [RQ11]
  assign z_im  = (off_s * 32'(i_i2_im)) / `NSD_OHM_DIV;  // [RQ11]
  assign p_re  = z_re - 32'(i_v2_re);                    // [RQ4] [RQ5]
  assign p_im  = z_im - 32'(i_v2_im);
  // Product with the conjugate current carries the angle between them. Only nine bits are
  // dropped, so a weak but valid polarizing voltage still resolves a direction.
  assign x_re  = 64'(p_re) * 64'(i_i2_re) + 64'(p_im) * 64'(i_i2_im);
  assign x_im  = 64'(p_im) * 64'(i_i2_re) - 64'(p_re) * 64'(i_i2_im);
  assign xs_re = 32'(x_re >>> `NSD_X_SHIFT);
  assign xs_im = 32'(x_im >>> `NSD_X_SHIFT);
  assign cos_e = $signed({16'h0, nsd_cos(q.characteristic_angle)});
  assign sin_e = $signed({16'h0, nsd_cos(`NSD_ANGLE_MAX - q.characteristic_angle)});
  // Turn the reference by the characteristic angle.
  assign y_re  = 64'(xs_re) * 64'(cos_e) + 64'(xs_im) * 64'(sin_e);  // [RQ5]
  assign y_im  = 64'(xs_im) * 64'(cos_e) - 64'(xs_re) * 64'(sin_e);
  assign ys_re = 32'(y_re >>> `NSD_Q);
  assign ys_im = 32'(y_im >>> `NSD_Q);
  assign yn_re = -ys_re;  // [RQ6]
  assign yn_im = -ys_im;

  nsd_sector u_fwd_sector (
    .i_re      (ys_re),
    .i_im      (ys_im),
    .i_lim_cos (nsd_cos(q.forward_angle_limit)),
    .o_within  (in_fwd)
  );

  nsd_sector u_rev_sector (
    .i_re      (yn_re),
    .i_im      (yn_im),
    .i_lim_cos (nsd_cos(q.reverse_angle_limit)),
    .o_within  (in_rev)
  );

  assign pol_valid = i_v2_mag > q.polarizing_voltage_floor;  // [RQ7]
  assign dir_fwd   = pol_valid && in_fwd;                    // [RQ5] [RQ7]
  assign dir_rev   = pol_valid && in_rev;                    // [RQ6] [RQ7]

  // ========================================================================
  // Current reversal and outputs.
  logic rev_armed;
  logic withheld;
  logic active;
  logic fwd_n;
  logic rev_n;

  assign rev_armed = q.rev_cnt == P_REV_HOLD_CLKS;                   // [RQ10]
  assign withheld  = q.hold_cnt != '0;                               // [RQ10]
  assign active    = q.enable && !i_block;                           // [RQ16]
  assign fwd_n     = active && ov_fwd && dir_fwd && !withheld;       // [RQ8] [RQ10] [RQ16]
  assign rev_n     = active && ov_rev && dir_rev;                    // [RQ9] [RQ16]

  // ========================================================================
  // Next state.
  always_comb begin
    logic [`NSD_EV_W-1:0] ev;
    logic [`NSD_EV_W-1:0] clr;
    ev  = '0;
    clr = '0;
    d   = q;
    d.rd_data = '0;
    // Reverse must be seen without a break before a later forward is held off.
    if (dir_rev) begin
      if (!rev_armed) begin
        d.rev_cnt = q.rev_cnt + 1'b1;  // [RQ10]
      end
    end else begin
      d.rev_cnt = '0;
    end
    if (dir_rev && rev_armed) begin
      d.hold_cnt = P_FWD_HOLD_CLKS;  // [RQ10]
      ev[`NSD_EV_HOLD] = !withheld;
    end else if (withheld) begin
      d.hold_cnt = q.hold_cnt - 1'b1;
    end
    d.fwd = fwd_n;
    d.rev = rev_n;
    ev[`NSD_EV_FWD] = fwd_n && !q.fwd;
    ev[`NSD_EV_REV] = rev_n && !q.rev;
    // Out of range writes saturate to the nearest legal setting after data bits 15:0 are taken.
    if (i_wr_en) begin
      case (i_addr)
        `NSD_A_CTRL: begin
          d.enable          = i_wr_data[`NSD_CTRL_EN];
          d.sequence_select = nsd_seq_type'(i_wr_data[`NSD_CTRL_SEQ]);
        end
        `NSD_A_OFFSET: begin
          d.offset_impedance = 15'(nsd_clamp(i_wr_data[15:0], 16'h0, 16'(`NSD_OFFSET_MAX)));
        end
        `NSD_A_RESTRAINT: begin
          d.positive_restraint_factor = 9'(nsd_clamp(i_wr_data[15:0], 16'h0,
                                                     16'(`NSD_K_MAX)));  // [RQ13]
        end
        `NSD_A_ANGLE: begin
          d.characteristic_angle = 7'(nsd_clamp(i_wr_data[15:0], 16'h0,
                                                16'(`NSD_ANGLE_MAX)));  // [RQ14]
        end
        `NSD_A_FWD_LIMIT: begin
          d.forward_angle_limit = 7'(nsd_clamp(i_wr_data[15:0], 16'(`NSD_LIM_MIN),
                                               16'(`NSD_LIM_MAX)));  // [RQ15]
        end
        `NSD_A_REV_LIMIT: begin
          d.reverse_angle_limit = 7'(nsd_clamp(i_wr_data[15:0], 16'(`NSD_LIM_MIN),
                                               16'(`NSD_LIM_MAX)));  // [RQ15]
        end
        `NSD_A_FWD_PICKUP: begin
          d.forward_threshold = 12'(nsd_clamp(i_wr_data[15:0], 16'(`NSD_PU_MIN),
                                              16'(`NSD_PU_MAX)));  // [RQ12]
        end
        `NSD_A_REV_PICKUP: begin
          d.reverse_threshold = 12'(nsd_clamp(i_wr_data[15:0], 16'(`NSD_PU_MIN),
                                              16'(`NSD_PU_MAX)));  // [RQ12]
        end
        `NSD_A_VFLOOR: begin
          d.polarizing_voltage_floor = i_wr_data[15:0];
        end
        `NSD_A_IRQ_STAT: begin
          clr = i_wr_data[`NSD_EV_W-1:0];
        end
        `NSD_A_IRQ_MASK: begin
          d.irq_mask = i_wr_data[`NSD_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // A new event in the clearing cycle survives the clear.
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.irq      = |(d.irq_stat & d.irq_mask);
    if (i_rd_en) begin
      case (i_addr)
        `NSD_A_CTRL: begin
          d.rd_data[`NSD_CTRL_EN]  = q.enable;
          d.rd_data[`NSD_CTRL_SEQ] = q.sequence_select;
        end
        `NSD_A_OFFSET:     d.rd_data = 32'(q.offset_impedance);
        `NSD_A_RESTRAINT:  d.rd_data = 32'(q.positive_restraint_factor);
        `NSD_A_ANGLE:      d.rd_data = 32'(q.characteristic_angle);
        `NSD_A_FWD_LIMIT:  d.rd_data = 32'(q.forward_angle_limit);
        `NSD_A_REV_LIMIT:  d.rd_data = 32'(q.reverse_angle_limit);
        `NSD_A_FWD_PICKUP: d.rd_data = 32'(q.forward_threshold);
        `NSD_A_REV_PICKUP: d.rd_data = 32'(q.reverse_threshold);
        `NSD_A_VFLOOR:     d.rd_data = 32'(q.polarizing_voltage_floor);
        `NSD_A_STATUS: begin
          d.rd_data[`NSD_ST_FWD]     = q.fwd;
          d.rd_data[`NSD_ST_REV]     = q.rev;
          d.rd_data[`NSD_ST_DIR_FWD] = dir_fwd;
          d.rd_data[`NSD_ST_DIR_REV] = dir_rev;
          d.rd_data[`NSD_ST_POL_OK]  = pol_valid;
          d.rd_data[`NSD_ST_HELD]    = withheld;
          d.rd_data[`NSD_ST_ACTIVE]  = active;
        end
        `NSD_A_IRQ_STAT:   d.rd_data = 32'(q.irq_stat);
        `NSD_A_IRQ_MASK:   d.rd_data = 32'(q.irq_mask);
        default:           d.rd_data = '0;
      endcase
    end
  end

  // ========================================================================
  // State register.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q                           <= '0;
      q.sequence_select           <= NSD_SEQ_NEG;
      q.positive_restraint_factor <= `NSD_K_RST;
      q.characteristic_angle      <= `NSD_ANGLE_RST;
      q.forward_angle_limit       <= `NSD_LIM_MAX;
      q.reverse_angle_limit       <= `NSD_LIM_MAX;
      q.forward_threshold         <= `NSD_PU_MIN;
      q.reverse_threshold         <= `NSD_PU_MIN;
      q.polarizing_voltage_floor  <= `NSD_VFLOOR_RST;
    end else begin
      q <= d;
    end
  end

  assign o_forward_fault_flag = q.fwd;
  assign o_reverse_fault_flag = q.rev;
  assign o_irq                = q.irq;
  assign o_rd_data            = q.rd_data;

  // ========================================================================
  // Checks.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  sequence s_rev_armed;
    dir_rev && rev_armed;
  endsequence

  sequence s_hold_loaded;
    q.hold_cnt == P_FWD_HOLD_CLKS;
  endsequence

  a_off_holds_low: assert property (!active |=>  // [RQ16]
    !o_forward_fault_flag && !o_reverse_fault_flag)
    else $error("Flag raised while element off or blocked.");
  a_pol_invalid_low: assert property (!pol_valid |=>  // [RQ7]
    !o_forward_fault_flag && !o_reverse_fault_flag)
    else $error("Flag raised without valid polarizing voltage.");
  a_fwd_needs_cause: assert property (o_forward_fault_flag |->  // [RQ8]
    $past(ov_fwd) && $past(dir_fwd))
    else $error("Forward flag without pickup and forward direction.");
  a_rev_needs_cause: assert property ($rose(o_reverse_fault_flag) |->  // [RQ9]
    $past(ov_rev) && $past(dir_rev) && $past(active))
    else $error("Reverse flag without pickup and reverse direction.");
  a_dir_exclusive: assert property (!(dir_fwd && dir_rev))  // [RQ5] [RQ6]
    else $error("Both directions indicated together.");
  a_restraint_off: assert property (q.positive_restraint_factor == 9'h000 |->  // [RQ2]
    op_q == 34'($signed({18'h0, sel_mag})) * `NSD_K_SCALE)
    else $error("Zero restraint factor still reduces the operating quantity.");
  a_mode_neutral_dir: assert property ($changed(q.sequence_select) && $stable(i_i2_re) &&  // [RQ4]
    $stable(i_i2_im) && $stable(i_v2_re) && $stable(i_v2_im) && $stable(i_v2_mag) &&
    $stable(q.polarizing_voltage_floor) |-> $stable(dir_fwd) && $stable(dir_rev))
    else $error("Direction depends on overcurrent mode.");
  a_reversal_hold: assert property (s_rev_armed |=> s_hold_loaded)  // [RQ10]
    else $error("Forward hold not started after sustained reverse.");
  a_withheld_fwd: assert property (withheld |=> !o_forward_fault_flag)  // [RQ10]
    else $error("Forward flag raised during reversal hold.");
  a_pickup_range: assert property (q.forward_threshold >= `NSD_PU_MIN &&  // [RQ12]
    q.forward_threshold <= `NSD_PU_MAX && q.reverse_threshold >= `NSD_PU_MIN &&
    q.reverse_threshold <= `NSD_PU_MAX)
    else $error("Pickup threshold out of range.");
  a_limit_range: assert property (q.forward_angle_limit >= `NSD_LIM_MIN &&  // [RQ15]
    q.reverse_angle_limit >= `NSD_LIM_MIN && q.characteristic_angle <= `NSD_ANGLE_MAX &&
    q.positive_restraint_factor <= `NSD_K_MAX)
    else $error("Angle or restraint setting out of range.");
  a_irq_level: assert property (o_irq == |(q.irq_stat & q.irq_mask))
    else $error("Interrupt output disagrees with status and mask.");
  a_event_sets_stat: assert property ($rose(o_forward_fault_flag) |->
    q.irq_stat[`NSD_EV_FWD])
    else $error("Forward rise did not set its status bit.");
  a_hold_counts_down: assert property (withheld && !(dir_rev && rev_armed) |=>  // [RQ10]
    q.hold_cnt == $past(q.hold_cnt) - 1'b1)
    else $error("Forward hold did not count down.");
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`include "nsd_cfg.svh"

module tb_top;
  import nsd_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals.
  logic         clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, blk = 1'b0;
  nsd_addr_type adr = 8'h00;
  nsd_word_type wd  = 32'h0, rdat;
  nsd_mag_type  m0  = 16'h0, m1 = 16'h0, m2 = 16'h0, vm = 16'h0;
  nsd_cpx_type  ir  = 16'sh0, vr = 16'sh0, vi = 16'sh0, zr = 16'sh0;
  logic         fwd, rev, irq;
  int           failures = 0, n_tests = 0;

  // Short hold counts keep the reversal scenario to a few dozen cycles.
  nsd_top #(.P_REV_HOLD_CLKS(22'h000014), .P_FWD_HOLD_CLKS(22'h00001E)) i_dut (
    .i_clk_sys(clk), .i_srst(rst), .i_addr(adr), .i_wr_data(wd), .i_wr_en(we),
    .i_rd_en(re), .o_rd_data(rdat), .i_i0_mag(m0), .i_i1_mag(m1), .i_i2_mag(m2),
    .i_v2_mag(vm), .i_i2_re(ir), .i_i2_im(zr), .i_v2_re(vr), .i_v2_im(vi),
    .i_block(blk), .o_forward_fault_flag(fwd), .o_reverse_fault_flag(rev), .o_irq(irq));

  always #5 clk = ~clk;

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input nsd_addr_type a, input nsd_word_type d);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    we  <= 1'b1;
    @(posedge clk);
    we  <= 1'b0;
  endtask

  task automatic rd(input nsd_addr_type a, input nsd_word_type e);
    @(posedge clk);
    adr <= a;
    re  <= 1'b1;
    @(posedge clk);
    re  <= 1'b0;
    #1 chk(rdat, e);
  endtask

  // Magnitudes and phasors are applied together, then the flags are judged.
  task automatic meas(input nsd_mag_type a0, a1, a2, input nsd_cpx_type i, v,
                      input logic [1:0] e);
    @(posedge clk);
    m0 <= a0;
    m1 <= a1;
    m2 <= a2;
    ir <= i;
    vr <= v;
    vm <= (v < 0) ? nsd_mag_type'(-v) : nsd_mag_type'(v);
    repeat (3) @(posedge clk);
    #1 chk({30'h0, rev, fwd}, {30'h0, e});
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_regs;
    rd(`NSD_A_RESTRAINT, 32'h3F);
    rd(`NSD_A_ANGLE, 32'h4B);
    rd(`NSD_A_FWD_LIMIT, 32'h5A);
    rd(`NSD_A_FWD_PICKUP, 32'h05);
    rd(8'h30, 32'h0);
    wr(`NSD_A_FWD_PICKUP, 32'h0);
    rd(`NSD_A_FWD_PICKUP, 32'h05);
    wr(`NSD_A_REV_PICKUP, 32'hBB9);
    rd(`NSD_A_REV_PICKUP, 32'hBB8);
    wr(`NSD_A_RESTRAINT, 32'h1F5);
    rd(`NSD_A_RESTRAINT, 32'h1F4);
    wr(`NSD_A_ANGLE, 32'h5B);
    rd(`NSD_A_ANGLE, 32'h5A);
    wr(`NSD_A_REV_LIMIT, 32'h27);
    rd(`NSD_A_REV_LIMIT, 32'h28);
    wr(`NSD_A_REV_LIMIT, 32'h5A);
    wr(`NSD_A_REV_PICKUP, 32'h05);
  endtask

  task automatic t_fwd;
    wr(`NSD_A_CTRL, 32'h1);
    wr(`NSD_A_ANGLE, 32'h0);
    wr(`NSD_A_RESTRAINT, 32'h0);
    meas(16'h0, 16'h7D0, 16'h3E8, 16'sh3E8, -16'sh3E8, 2'b01);
    wr(`NSD_A_RESTRAINT, 32'h1F4);
    meas(16'h0, 16'h7D0, 16'h3E8, 16'sh3E8, -16'sh3E8, 2'b00);
    meas(16'h0, 16'h7BC, 16'h3E8, 16'sh3E8, -16'sh3E8, 2'b01);
    wr(`NSD_A_FWD_PICKUP, 32'h0A);
    meas(16'h0, 16'h7BC, 16'h3E8, 16'sh3E8, -16'sh3E8, 2'b00);
    wr(`NSD_A_FWD_PICKUP, 32'h05);
    wr(`NSD_A_RESTRAINT, 32'h7D);
    meas(16'h0, 16'h1F00, 16'h3E8, 16'sh3E8, -16'sh3E8, 2'b01);
    meas(16'h0, 16'h1F40, 16'h3E8, 16'sh3E8, -16'sh3E8, 2'b00);
    wr(`NSD_A_RESTRAINT, 32'h0);
    wr(`NSD_A_CTRL, 32'h3);
    meas(16'h3E8, 16'h0, 16'h0, 16'sh3E8, -16'sh3E8, 2'b01);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, -16'sh3E8, 2'b00);
    wr(`NSD_A_CTRL, 32'h1);
  endtask

  task automatic t_rev;
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, 16'sh3E8, 2'b10);
    wr(`NSD_A_REV_PICKUP, 32'h3E8);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, 16'sh3E8, 2'b00);
    wr(`NSD_A_REV_PICKUP, 32'h05);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, 16'sh10, 2'b00);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, -16'sh10, 2'b00);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, -16'sh11, 2'b01);
  endtask

  task automatic t_blk;
    @(posedge clk);
    blk <= 1'b1;
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, -16'sh3E8, 2'b00);
    @(posedge clk);
    blk <= 1'b0;
    wr(`NSD_A_CTRL, 32'h0);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, -16'sh3E8, 2'b00);
    wr(`NSD_A_CTRL, 32'h1);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, 16'sh1F4, 2'b10);
    wr(`NSD_A_OFFSET, 32'h64);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, 16'sh1F4, 2'b01);
    wr(`NSD_A_OFFSET, 32'h0);
  endtask

  task automatic t_hold;
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, 16'sh3E8, 2'b10);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, -16'sh3E8, 2'b01);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, 16'sh3E8, 2'b10);
    repeat (30) @(posedge clk);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, -16'sh3E8, 2'b00);
    repeat (40) @(posedge clk);
    #1 chk({30'h0, rev, fwd}, 32'h1);
    rd(`NSD_A_IRQ_STAT, 32'h7);
  endtask

  task automatic t_ang;
    wr(`NSD_A_FWD_LIMIT, 32'h28);
    @(posedge clk);
    vi <= -16'sh2C3;
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, -16'sh2C3, 2'b00);
    wr(`NSD_A_FWD_LIMIT, 32'h32);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, -16'sh2C3, 2'b01);
    wr(`NSD_A_FWD_LIMIT, 32'h28);
    wr(`NSD_A_ANGLE, 32'h2D);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, -16'sh2C3, 2'b01);
    rd(`NSD_A_STATUS, 32'h55);
    wr(`NSD_A_ANGLE, 32'h0);
    wr(`NSD_A_FWD_LIMIT, 32'h5A);
    @(posedge clk);
    vi <= 16'sh0;
  endtask

  task automatic t_irq;
    meas(16'h0, 16'h0, 16'h0, 16'sh0, 16'sh0, 2'b00);
    wr(`NSD_A_IRQ_STAT, 32'h7);
    rd(`NSD_A_IRQ_STAT, 32'h0);
    wr(`NSD_A_IRQ_MASK, 32'h1);
    meas(16'h0, 16'h0, 16'h3E8, 16'sh3E8, -16'sh3E8, 2'b01);
    rd(`NSD_A_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(`NSD_A_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
    wr(`NSD_A_IRQ_STAT, 32'h1);
    wr(`NSD_A_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
  endtask

  // ==========================================================================
  // Sequence, watchdog and verdict.
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_fwd;
    t_rev;
    t_blk;
    t_hold;
    t_ang;
    t_irq;
    end_of_test;
  end

  // The scenarios need well under a thousand cycles; this limit catches a hang.
  initial begin
    #20000;
    failures++;
    end_of_test;
  end
endmodule
